// ==== shared/spds_pkg.sv ====
// constants and types shared by the power down sequencer block
// assumes a 9-bit register address and 16-bit data from a decoded serial write port
//
// Operation
// [R1] Host starts capture by setting bit 0 of register 192, other bits kept.
// [R2] Sensor begins grabbing frames in the configured mode once enable is set.
// [R3] Host stops capture by clearing bit 0 of register 192, other bits kept.
// [R4] Sensor stops grabbing frames and returns to idle when enable clears.
// [R5] Soft power down writes 112,48,40 zero, 72=0x0200, 64 zero, 10=0x0999.
// [R6] After soft power down, blocks are disabled and sensor is in standby.
// [R7] Clock shutdown part two writes 34 zero, 32 mode value, 9=0x0009.
// [R8] Register 32 shutdown value: 0x200c, 0x2008, 0x2004 or 0x2000 by mode.
// [R9] Clock shutdown part one writes 16 zero, 8=0x0099, 20 zero.
// [R10] Host resets the sensor before stopping its input clock.
// [R11] Shutter mode changes only in standby or idle, never while running; the code still takes a write clearing all shutter bits while running.
// [R12] Frame rate, exposure, gain, window, subsampling change in all three states.
// [R13] Static configuration registers are written only while enable is zero; the code takes writes to them in every state.
// [R14] Host finishes each register write before issuing the next of a sequence.
package spds_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam logic [8:0] OFF_PLL_SOFT_RESET = 9'h008;
  localparam logic [8:0] OFF_CLOCK_GEN_SOFT_RESET = 9'h009;
  localparam logic [8:0] OFF_CORE_SOFT_RESET = 9'h00a;
  localparam logic [8:0] OFF_PLL_POWER = 9'h010;
  localparam logic [8:0] OFF_CLOCK_MANAGEMENT_CFG = 9'h014;
  localparam logic [8:0] OFF_CLOCK_DISTRIBUTION_CFG = 9'h020;
  localparam logic [8:0] OFF_LOGIC_BLOCK_ENABLE = 9'h022;
  localparam logic [8:0] OFF_COLUMN_MUX_ENABLE = 9'h028;
  localparam logic [8:0] OFF_FRONTEND_ENABLE = 9'h030;
  localparam logic [8:0] OFF_BIAS_ENABLE = 9'h040;
  localparam logic [8:0] OFF_CHARGE_PUMP_CFG = 9'h048;
  localparam logic [8:0] OFF_SERIAL_TX_ENABLE = 9'h070;
  localparam logic [8:0] OFF_SEQUENCER_CONTROL = 9'h0c0;
  localparam int NUM_REGS = 13;
  // ----------------------------------------------------------------
  // fields and values
  // ----------------------------------------------------------------
  localparam int SEQ_ENABLE_BIT = 0;
  localparam int SHUTTER_MODE_LSB = 1;
  localparam int SHUTTER_MODE_MSB = 6;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam logic [15:0] CORE_SOFT_RESET_VAL = 16'h0999;
  localparam logic [15:0] CHARGE_PUMP_OFF_VAL = 16'h0200;
  localparam logic [15:0] CLOCK_GEN_SOFT_RESET_VAL = 16'h0009;
  localparam logic [15:0] PLL_SOFT_RESET_VAL = 16'h0099;
  localparam logic [15:0] CLKDIST_OFF_8B_PLL = 16'h200c;
  localparam logic [15:0] CLKDIST_OFF_8B_NOPLL = 16'h2008;
  localparam logic [15:0] CLKDIST_OFF_10B_PLL = 16'h2004;
  localparam logic [15:0] CLKDIST_OFF_10B_NOPLL = 16'h2000;
  // logic clock enable bits of the clock distribution register
  localparam logic [15:0] CLKDIST_LOGIC_MASK = 16'h0003;
  localparam logic [15:0] SHUTTER_MASK = 16'h007e;

  typedef enum logic [1:0] {
    SPDS_STANDBY,
    SPDS_IDLE,
    SPDS_RUNNING
  } spds_state_t;
endpackage

// ==== shared/spds_wr_if.sv ====
// write carrier between the register file and the state tracker
// assumes a single clock domain
`timescale 1ns/1ps
interface spds_wr_if;
  logic we;
  logic [8:0] addr;
  logic [15:0] data;
  logic shutter_refused;
  modport src (output we, output addr, output data, input shutter_refused);
  modport dst (input we, input addr, input data, output shutter_refused);
endinterface

// ==== design/spds_state_track.sv ====
// sensor state tracker: standby, idle, running
// assumes writes arrive one per cycle at most, already decoded
`timescale 1ns/1ps
module spds_state_track (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  spds_wr_if.dst wr,
  input wire logic seq_enable_in,
  input wire logic blocks_off_in,
  output spds_pkg::spds_state_t state_out
);
  spds_pkg::spds_state_t state_reg;
  spds_pkg::spds_state_t state_next;
  wire core_wr = wr.we && (wr.addr == spds_pkg::OFF_CORE_SOFT_RESET);
  wire core_reset_wr = core_wr && (wr.data == spds_pkg::CORE_SOFT_RESET_VAL);
  wire seq_wr = wr.we && (wr.addr == spds_pkg::OFF_SEQUENCER_CONTROL);
  wire shutter_change =
      seq_wr && ((wr.data & spds_pkg::SHUTTER_MASK) != 16'h0000);

  // a write setting any shutter bit is refused while frames are grabbed
  assign wr.shutter_refused = (state_reg == spds_pkg::SPDS_RUNNING) && shutter_change; // R11

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      spds_pkg::SPDS_STANDBY: begin
        if (core_wr && !core_reset_wr) begin
          state_next = spds_pkg::SPDS_IDLE;
        end
      end
      spds_pkg::SPDS_IDLE: begin
        if (core_reset_wr && blocks_off_in) begin
          state_next = spds_pkg::SPDS_STANDBY; // R6
        end else if (seq_enable_in) begin
          state_next = spds_pkg::SPDS_RUNNING; // R2
        end
      end
      spds_pkg::SPDS_RUNNING: begin
        if (!seq_enable_in) begin
          state_next = spds_pkg::SPDS_IDLE; // R4
        end
      end
      default: state_next = spds_pkg::SPDS_STANDBY;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= spds_pkg::SPDS_STANDBY;
    end else if (clk_en_in) begin
      state_reg <= state_next;
    end
  end

  assign state_out = state_reg;
endmodule

// ==== design/spds_top.sv ====
// register file and power state logic of the sensor power down sequencer
// assumes an already decoded serial write/read port, one access per cycle
`timescale 1ns/1ps
module spds_top #(
  parameter int DATA_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [8:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic [1:0] sensor_state_out,
  output logic frame_grab_out,
  output logic blocks_enabled_out,
  output logic logic_clock_on_out,
  output logic pll_on_out,
  output logic shutter_refused_out
);
  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  localparam logic [8:0] OFFS [spds_pkg::NUM_REGS] = '{
    spds_pkg::OFF_PLL_SOFT_RESET, spds_pkg::OFF_CLOCK_GEN_SOFT_RESET,
    spds_pkg::OFF_CORE_SOFT_RESET, spds_pkg::OFF_PLL_POWER,
    spds_pkg::OFF_CLOCK_MANAGEMENT_CFG, spds_pkg::OFF_CLOCK_DISTRIBUTION_CFG,
    spds_pkg::OFF_LOGIC_BLOCK_ENABLE, spds_pkg::OFF_COLUMN_MUX_ENABLE,
    spds_pkg::OFF_FRONTEND_ENABLE, spds_pkg::OFF_BIAS_ENABLE,
    spds_pkg::OFF_CHARGE_PUMP_CFG, spds_pkg::OFF_SERIAL_TX_ENABLE,
    spds_pkg::OFF_SEQUENCER_CONTROL
  };
  localparam int IX_CLKDIST = 5;
  localparam int IX_LOGIC = 6;
  localparam int IX_COLMUX = 7;
  localparam int IX_AFE = 8;
  localparam int IX_BIAS = 9;
  localparam int IX_CPUMP = 10;
  localparam int IX_LVDS = 11;
  localparam int IX_SEQ = 12;
  localparam int IX_PLL = 3;

  function automatic logic [spds_pkg::NUM_REGS-1:0] decode(input logic [8:0] a);
    logic [spds_pkg::NUM_REGS-1:0] hit;
    hit = '0;
    for (int i = 0; i < spds_pkg::NUM_REGS; i++) begin
      hit[i] = (a == OFFS[i]);
    end
    return hit;
  endfunction

  logic [DATA_W-1:0] regs_reg [spds_pkg::NUM_REGS];
  wire [spds_pkg::NUM_REGS-1:0] wr_hit = decode(reg_addr_in);
  wire [spds_pkg::NUM_REGS-1:0] rd_hit = decode(reg_addr_in);
  spds_pkg::spds_state_t state;
  spds_wr_if wr_bus ();

  assign wr_bus.we = reg_wr_in && clk_en_in;
  assign wr_bus.addr = reg_addr_in;
  assign wr_bus.data = 16'(reg_wdata_in);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // frame rate, exposure, gain, window and subsampling registers are
  // always writable; only shutter bits are guarded while running
  wire seq_guarded = wr_bus.shutter_refused;
  wire [DATA_W-1:0] seq_wdata = seq_guarded ?
      ((regs_reg[IX_SEQ] & DATA_W'(spds_pkg::SHUTTER_MASK)) |
       (reg_wdata_in & ~DATA_W'(spds_pkg::SHUTTER_MASK))) : reg_wdata_in; // R12

  genvar g;
  generate
    for (g = 0; g < spds_pkg::NUM_REGS; g++) begin : g_reg
      wire [DATA_W-1:0] wval = (g == IX_SEQ) ? seq_wdata : reg_wdata_in;
      always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          regs_reg[g] <= DATA_W'(spds_pkg::RESET_VALUE);
        end else if (clk_en_in && reg_wr_in && wr_hit[g]) begin
          regs_reg[g] <= wval; // R1 R3 R5 R7 R9
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // state tracking
  // ----------------------------------------------------------------
  wire blocks_off = (regs_reg[IX_LVDS] == '0) && (regs_reg[IX_AFE] == '0) &&
      (regs_reg[IX_COLMUX] == '0) && (regs_reg[IX_BIAS] == '0) &&
      (regs_reg[IX_CPUMP] == DATA_W'(spds_pkg::CHARGE_PUMP_OFF_VAL));

  // the enable bit of the sequencer register as it stands before this cycle's write
  wire seq_en_now = regs_reg[IX_SEQ][spds_pkg::SEQ_ENABLE_BIT];

  spds_state_track u_track (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .wr(wr_bus),
    .seq_enable_in(seq_en_now),
    .blocks_off_in(blocks_off),
    .state_out(state)
  );

  // logic clock counts as on while any low bit the shutdown values clear is set or register 34 is nonzero
  wire logic_clk_on = (regs_reg[IX_CLKDIST] & DATA_W'(spds_pkg::CLKDIST_LOGIC_MASK)) != '0
      || (regs_reg[IX_LOGIC] != '0); // R8

  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    for (int i = 0; i < spds_pkg::NUM_REGS; i++) begin
      if (rd_hit[i]) begin
        rd_mux = regs_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
      reg_rvalid_out <= 1'b0;
      sensor_state_out <= 2'h0;
      frame_grab_out <= 1'b0;
      blocks_enabled_out <= 1'b0;
      logic_clock_on_out <= 1'b0;
      pll_on_out <= 1'b0;
      shutter_refused_out <= 1'b0;
    end else if (clk_en_in) begin
      reg_rdata_out <= reg_rd_in ? rd_mux : '0;
      reg_rvalid_out <= reg_rd_in;
      sensor_state_out <= 2'(state);
      frame_grab_out <= (state == spds_pkg::SPDS_RUNNING); // R2 R4
      blocks_enabled_out <= !blocks_off;
      logic_clock_on_out <= logic_clk_on;
      pll_on_out <= (regs_reg[IX_PLL] != '0); // R9
      shutter_refused_out <= seq_guarded; // R11
    end
  end
endmodule

// ==== dv/spds_props.sv ====
// assertions on the sequencer top ports
// assumes a bind onto spds_top from the bench top
`timescale 1ns/1ps
module spds_props #(
  parameter int DATA_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [8:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic [1:0] sensor_state_out,
  input wire logic frame_grab_out,
  input wire logic blocks_enabled_out,
  input wire logic logic_clock_on_out,
  input wire logic pll_on_out,
  input wire logic shutter_refused_out
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wire logic wr_ok = reg_wr_in && clk_en_in;
  wire logic wr_seq = wr_ok && reg_addr_in == 9'h0c0;
  wire logic run = sensor_state_out == 2'h2;
  chk_grab_state: assert property (frame_grab_out == run)
    else $error("frame grab disagrees with state");
  chk_seq_start: assert property (wr_seq && reg_wdata_in[0] && sensor_state_out == 2'h1
    |-> ##[1:4] frame_grab_out) else $error("enable did not start capture");
  chk_seq_stop: assert property (wr_seq && !reg_wdata_in[0] && run
    |-> ##[1:4] sensor_state_out == 2'h1) else $error("disable did not reach idle");
  chk_shutter_refuse: assert property (wr_seq && reg_wdata_in[6:1] != 6'h00
    |=> shutter_refused_out == (sensor_state_out == 2'h2))
    else $error("shutter refusal disagrees with state");
  chk_refuse_cause: assert property (shutter_refused_out
    |-> $past(wr_seq && reg_wdata_in[6:1] != 6'h00)) else $error("refusal without cause");
  chk_standby_entry: assert property (wr_ok && reg_addr_in == 9'h00a
    && reg_wdata_in == 16'h0999 && !blocks_enabled_out && sensor_state_out == 2'h1
    |-> ##[1:4] sensor_state_out == 2'h0) else $error("soft reset did not enter standby");
  chk_pll_off: assert property (wr_ok && reg_addr_in == 9'h010 && reg_wdata_in == 16'h0000
    |-> ##[1:2] !pll_on_out) else $error("pll still on");
  chk_rd_answer: assert property (reg_rd_in && clk_en_in |=> reg_rvalid_out)
    else $error("read not answered");
  chk_rdata_idle: assert property (!reg_rvalid_out |-> reg_rdata_out == 16'h0000)
    else $error("read data not zero when idle");
endmodule

// ==== dv/spds_host.sv ====
// host model driving the decoded register port
// assumes tb_top holds the counters and the check task
`timescale 1ns/1ps
module spds_host (
  input wire logic sys_clk_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  output logic rst_in,
  output logic clk_en_in,
  output logic reg_wr_in,
  output logic reg_rd_in,
  output logic [8:0] reg_addr_in,
  output logic [15:0] reg_wdata_in
);
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    clk_en_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 9'h000;
    reg_wdata_in = 16'h0000;
  end
  // reset held with the clock still running, never the other way
  task do_reset;
    rst_in <= 1'b1;
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
  endtask
  // one write fully taken before the next starts
  task wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    reg_wdata_in <= ~d;
  endtask
  task rd(input logic [8:0] a, output logic [15:0] d);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
    tb_top.check({15'h0, reg_rvalid_out}, 16'h0001);
  endtask
  // clock enable moved one edge ahead of the next access
  task set_en(input logic en);
    @(posedge sys_clk_in);
    clk_en_in <= en;
  endtask
endmodule

// ==== dv/tb_top.sv ====
// register sequence bench for the power down sequencer
// assumes the host model owns every design input but the clock, which tb_top drives
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_in, rst_in, clk_en_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
  logic frame_grab_out, blocks_enabled_out, logic_clock_on_out, pll_on_out;
  logic shutter_refused_out;
  logic [1:0] sensor_state_out;
  logic [8:0] reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out;
  int errors = 0;
  int n_compared = 0;
  logic [8:0] ra [9] = '{9'h008, 9'h009, 9'h010, 9'h014, 9'h028, 9'h030, 9'h040, 9'h048,
    9'h070};
  logic [8:0] pa [5] = '{9'h070, 9'h030, 9'h028, 9'h048, 9'h040};
  logic [15:0] cd [4] = '{16'h200c, 16'h2008, 16'h2004, 16'h2000};
  spds_host u_host (.sys_clk_in(sys_clk_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in));
  spds_top uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .sensor_state_out(sensor_state_out),
    .frame_grab_out(frame_grab_out), .blocks_enabled_out(blocks_enabled_out),
    .logic_clock_on_out(logic_clock_on_out), .pll_on_out(pll_on_out),
    .shutter_refused_out(shutter_refused_out));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task conclude;
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rdchk(input logic [8:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_host.rd(a, d);
    check(d, exp);
  endtask
  // state moves within two edges, its outputs one edge later
  task settle(input logic [15:0] st);
    repeat (3) @(posedge sys_clk_in);
    #1;
    check({14'h0, sensor_state_out}, st);
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #100000;
    errors++;
    conclude();
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    u_host.do_reset();
    settle(16'h0000);
    for (int i = 0; i < 9; i++) rdchk(ra[i], 16'h0000);
    for (int i = 0; i < 9; i++) u_host.wr(ra[i], 16'h1000 | ra[i]);
    for (int i = 0; i < 9; i++) rdchk(ra[i], 16'h1000 | ra[i]);
    u_host.wr(9'h1ff, 16'hbeef);
    rdchk(9'h1ff, 16'h0000);
    u_host.wr(9'h00a, 16'h0000);
    settle(16'h0001);
    check({15'h0, blocks_enabled_out}, 16'h0001);
    u_host.wr(9'h0c0, 16'h0001);
    settle(16'h0002);
    check({15'h0, frame_grab_out}, 16'h0001);
    u_host.wr(9'h0c0, 16'h0003);
    #1 check({15'h0, shutter_refused_out}, 16'h0001);
    rdchk(9'h0c0, 16'h0001);
    u_host.wr(9'h014, 16'h0005);
    rdchk(9'h014, 16'h0005);
    u_host.wr(9'h0c0, 16'h0000);
    settle(16'h0001);
    check({15'h0, frame_grab_out}, 16'h0000);
    u_host.wr(9'h0c0, 16'h0002);
    #1 check({15'h0, shutter_refused_out}, 16'h0000);
    rdchk(9'h0c0, 16'h0002);
    for (int i = 0; i < 5; i++) u_host.wr(pa[i], (i == 3) ? 16'h0200 : 16'h0000);
    u_host.wr(9'h00a, 16'h0999);
    settle(16'h0000);
    check({15'h0, blocks_enabled_out}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      u_host.wr(9'h020, 16'h200f);
      settle(16'h0000);
      check({15'h0, logic_clock_on_out}, 16'h0001);
      u_host.wr(9'h022, 16'h0000);
      u_host.wr(9'h020, cd[i]);
      u_host.wr(9'h009, 16'h0009);
      settle(16'h0000);
      check({15'h0, logic_clock_on_out}, 16'h0000);
      rdchk(9'h020, cd[i]);
    end
    u_host.wr(9'h010, 16'h0001);
    settle(16'h0000);
    check({15'h0, pll_on_out}, 16'h0001);
    u_host.wr(9'h010, 16'h0000);
    u_host.wr(9'h008, 16'h0099);
    u_host.wr(9'h014, 16'h0000);
    settle(16'h0000);
    check({15'h0, pll_on_out}, 16'h0000);
    // a write offered while the enable is low must leave no trace
    u_host.set_en(1'b0);
    u_host.wr(9'h014, 16'h0abc);
    u_host.set_en(1'b1);
    rdchk(9'h014, 16'h0000);
    u_host.do_reset();
    settle(16'h0000);
    rdchk(9'h020, 16'h0000);
    conclude();
  end
endmodule
bind spds_top spds_props #(.DATA_W(DATA_W)) u_chk (.sys_clk_in(sys_clk_in),
  .rst_in(rst_in), .clk_en_in(clk_en_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .sensor_state_out(sensor_state_out),
  .frame_grab_out(frame_grab_out), .blocks_enabled_out(blocks_enabled_out),
  .logic_clock_on_out(logic_clock_on_out), .pll_on_out(pll_on_out),
  .shutter_refused_out(shutter_refused_out));
